// File: core/bcs_consts.vh
// Constants of the converter setting register bank.
// Included by the bank module; holds definitions only.
`ifndef BCS_CONSTS_VH
`define BCS_CONSTS_VH
`define BCS_ADDR_SECOND 8'h17
`define BCS_ADDR_THIRD 8'h18
`define BCS_ADDR_FOURTH 8'h19
`define BCS_ADDR_SLEW 8'h1a
`define BCS_BIT_PULSE_SKIP 7
`define BCS_BIT_RESERVED 6
`define BCS_CODE_MSB 5
`define BCS_BIT_GO 7
`define BCS_BIT_GO_NO_SLEW 6
`define BCS_RST_SECOND 8'h99
`define BCS_RST_THIRD 8'hbd
`define BCS_RST_FOURTH 8'h94
`define BCS_RST_SECOND_CODE 6'h19
`define BCS_RST_THIRD_CODE 6'h3d
`define BCS_RST_FOURTH_CODE 6'h14
`define BCS_RST_PULSE_SKIP 3'h7
`define BCS_WRITE_MASK 8'hbf
`define BCS_FOURTH_CODE_MAX 6'h34
`define BCS_BLANK_TIME_US 5000
`define BCS_CLK_MHZ 40
`define BCS_BLANK_CYCLES (`BCS_BLANK_TIME_US * `BCS_CLK_MHZ)
`endif

// File: core/bcs_setting_regs.v
// Setting registers of three switching converters: pulse-skip bit and voltage code.
// Assumes a serial register front end that presents one-cycle write strobes and a
// read address, a password unit that grants writes, and resistor-select defaults.
`timescale 1ns/1ps
`include "bcs_consts.vh"

// Operation
// - Setting register writes land only while the password unit grants them.
// - Each write blanks that converter's voltage supervision for five milliseconds.
// - Second converter takes a new code only after go or go-no-slew is set.
// - Bit 7 is read-write pulse-skip enable, reset one; zero forces fixed frequency.
// - Second converter code in bits 5..0 resets to 19h.
// - Third converter code in bits 5..0 resets to 3Dh.
// - Registers reset to 0x99, 0xBD, 0x94 unless resistor select says otherwise.
// - Third and fourth defaults come from the resistor select input.
// - Fourth converter code in bits 5..0 resets to 14h.
// - Fourth codes 35h to 3Fh are reserved; 0h to 34h span 1.175 to 3.400 V.
module bcs_setting_regs #(
    parameter BLANK_CYCLES = `BCS_BLANK_CYCLES,
    parameter [7:0] THIRD_ALT_RESET = `BCS_RST_THIRD,
    parameter [7:0] FOURTH_ALT_RESET = `BCS_RST_FOURTH
) (
    input wire clk_in,
    input wire rst_in,
    input wire wr_en_in,
    input wire [7:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    input wire write_grant_in,
    input wire [7:0] rd_addr_in,
    input wire resistor_default_select_in,
    input wire converter_enable_fourth_in,
    output reg [7:0] rd_data_out,
    output reg [2:0] pulse_skip_enable_out,
    output reg [5:0] second_converter_voltage_code_out,
    output reg [5:0] third_converter_voltage_code_out,
    output reg [5:0] fourth_converter_voltage_code_out,
    output reg [2:0] supervision_blank_out,
    output reg fourth_code_reserved_out
);
    // Sized for the default 5 ms count at 40 MHz; a longer blank needs a wider counter
    localparam CNT_W = 18;
    localparam [31:0] BLANK_LOAD_FULL = BLANK_CYCLES - 1;
    localparam [CNT_W-1:0] BLANK_LOAD = BLANK_LOAD_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'h0}};

    // Register images; bit 6 is never stored as one
    reg [7:0] second_reg;
    reg [7:0] third_reg;
    reg [7:0] fourth_reg;
    reg straps_loaded;
    reg [CNT_W-1:0] blank_cnt [0:2];
    reg [7:0] next_rd_data;
    wire write_allowed;
    wire [2:0] wr_hit;
    wire [2:0] rd_hit;
    wire [7:0] wr_clean;
    wire strap_take;
    wire slew_write;
    wire go_bits_set;
    wire go_seen;
    wire [5:0] next_second_code;
    wire [2:0] next_pulse_skip;
    wire fourth_code_reserved;
    wire fourth_change_running;

    // One-hot hit vector over the three setting registers, shared by write and read
    function [2:0] decode;
        input [7:0] addr;
        begin
            decode = {addr == `BCS_ADDR_FOURTH, addr == `BCS_ADDR_THIRD,
                      addr == `BCS_ADDR_SECOND};
        end
    endfunction

    // Write path
    assign write_allowed = wr_en_in & write_grant_in;
    assign wr_hit = decode(wr_addr_in) & {3{write_allowed}};
    assign wr_clean = wr_data_in & `BCS_WRITE_MASK;
    assign strap_take = !straps_loaded && resistor_default_select_in;

    // The slew register lives elsewhere; its writes are only watched for the go bits
    assign slew_write = wr_en_in && (wr_addr_in == `BCS_ADDR_SLEW);
    assign go_bits_set = wr_data_in[`BCS_BIT_GO] || wr_data_in[`BCS_BIT_GO_NO_SLEW];
    assign go_seen = slew_write && go_bits_set;
    // A write and a go in one cycle apply the value written in that cycle
    assign next_second_code = wr_hit[0] ? wr_clean[`BCS_CODE_MSB:0]
                                        : second_reg[`BCS_CODE_MSB:0];

    // Read path
    assign rd_hit = decode(rd_addr_in);

    always @* begin
        case (rd_hit)
            3'h1: next_rd_data = second_reg;
            3'h2: next_rd_data = third_reg;
            3'h4: next_rd_data = fourth_reg;
            default: next_rd_data = 8'h00;
        endcase
    end

    // Pulse-skip bits per converter: [0] second, [1] third, [2] fourth
    assign next_pulse_skip = {fourth_reg[`BCS_BIT_PULSE_SKIP], third_reg[`BCS_BIT_PULSE_SKIP],
                              second_reg[`BCS_BIT_PULSE_SKIP]};
    assign fourth_code_reserved = fourth_reg[`BCS_CODE_MSB:0] > `BCS_FOURTH_CODE_MAX;
    // Misuse detector only: the write itself is still taken
    assign fourth_change_running = wr_hit[2] && converter_enable_fourth_in;

    // The strap is caught once, at the first edge after reset release
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            straps_loaded <= 1'h0;
        end else begin
            straps_loaded <= 1'h1;
        end
    end

    // Second converter setting; it has no strap alternative
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            second_reg <= `BCS_RST_SECOND;
        end else if (wr_hit[0]) begin
            second_reg <= wr_clean;
        end
    end

    // A write in the strap cycle wins over the resistor default
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            third_reg <= `BCS_RST_THIRD;
        end else if (wr_hit[1]) begin
            third_reg <= wr_clean;
        end else if (strap_take) begin
            third_reg <= THIRD_ALT_RESET & `BCS_WRITE_MASK;
        end
    end

    // Stored as written; reserved codes are kept and only raise the reserved flag
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fourth_reg <= `BCS_RST_FOURTH;
        end else if (wr_hit[2]) begin
            fourth_reg <= wr_clean;
        end else if (strap_take) begin
            fourth_reg <= FOURTH_ALT_RESET & `BCS_WRITE_MASK;
        end
    end

    // Applied code of the second converter; moves only on a go write
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            second_converter_voltage_code_out <= `BCS_RST_SECOND_CODE;
        end else if (go_seen) begin
            second_converter_voltage_code_out <= next_second_code;
        end
    end

    // Per-converter blanking timers; a rewrite during blanking restarts the interval
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_blank
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    blank_cnt[i] <= CNT_ZERO;
                    supervision_blank_out[i] <= 1'h0;
                end else if (wr_hit[i]) begin
                    blank_cnt[i] <= BLANK_LOAD;
                    supervision_blank_out[i] <= 1'h1;
                end else if (blank_cnt[i] != CNT_ZERO) begin
                    blank_cnt[i] <= blank_cnt[i] - 1'h1;
                end else begin
                    supervision_blank_out[i] <= 1'h0;
                end
            end
        end
    endgenerate

    // Read data lags the address by one edge; unmapped addresses read zero
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_skip_enable_out <= `BCS_RST_PULSE_SKIP;
        end else begin
            pulse_skip_enable_out <= next_pulse_skip;
        end
    end

    // Third and fourth codes follow their registers one edge later
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            third_converter_voltage_code_out <= `BCS_RST_THIRD_CODE;
        end else begin
            third_converter_voltage_code_out <= third_reg[`BCS_CODE_MSB:0];
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fourth_converter_voltage_code_out <= `BCS_RST_FOURTH_CODE;
        end else begin
            fourth_converter_voltage_code_out <= fourth_reg[`BCS_CODE_MSB:0];
        end
    end

    // Flags a reserved code, or a change made while the converter runs
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fourth_code_reserved_out <= 1'h0;
        end else begin
            fourth_code_reserved_out <= fourth_code_reserved || fourth_change_running;
        end
    end
endmodule // bcs_setting_regs

// File: test/bcs_regs_asserts.sv
// Checker for the converter setting bank, bound to its ports.
// Assumes the bench sets a blanking count of 20 cycles.
`timescale 1ns/1ps
module bcs_regs_chk (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic write_grant_in,
    input wire logic fourth_code_reserved_out,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_data_out,
    input wire logic [5:0] second_converter_voltage_code_out,
    input wire logic [5:0] fourth_converter_voltage_code_out,
    input wire logic [2:0] pulse_skip_enable_out,
    input wire logic [2:0] supervision_blank_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic ok = wr_en_in && write_grant_in;
    wire logic [2:0] bl = supervision_blank_out;
    wire logic [5:0] c4 = fourth_converter_voltage_code_out;
    blank_set_a: assert property (ok && wr_addr_in == 8'h17 |=> bl[0])
        else $error("no blank");
    blank_len_a: assert property ($rose(bl[0]) |-> ##19 bl[0] ##1 !bl[0])
        else $error("blank length");
    locked_a: assert property (wr_en_in && !write_grant_in && wr_addr_in == 8'h18 && !bl[1]
        |=> !bl[1]) else $error("locked write acted");
    bit6_zero_a: assert property (rd_data_out[6] == 1'b0) else $error("bit6 set");
    go_only_a: assert property ($changed(second_converter_voltage_code_out)
        |-> $past(wr_en_in && wr_addr_in == 8'h1a && (wr_data_in[7] || wr_data_in[6])))
        else $error("code moved");
    code_follow_a: assert property (ok && wr_addr_in == 8'h19
        |=> ##1 c4 == $past(wr_data_in[5:0], 2)) else $error("code lost");
    skip_follow_a: assert property (ok && wr_addr_in == 8'h17
        |=> ##1 pulse_skip_enable_out[0] == $past(wr_data_in[7], 2)) else $error("skip lost");
    resv_flag_a: assert property (c4 > 6'h34 |-> ##[0:1] fourth_code_reserved_out)
        else $error("no flag");
    cover property (wr_en_in && wr_addr_in == 8'h1a);
    cover property (wr_en_in && !write_grant_in);
    cover property ($fell(bl[0]));
endmodule // bcs_regs_chk
bind bcs_setting_regs bcs_regs_chk i_chk (.*);

// File: test/bcs_host.sv
// Host model: serial register master with one-cycle write strobes.
// Assumes read data settles one edge after the address.
`timescale 1ns/1ps
module bcs_host (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    output logic wr_en_out = 1'b0,
    output logic [7:0] wr_addr_out = 8'h00,
    output logic [7:0] wr_data_out = 8'h00,
    output logic [7:0] rd_addr_out = 8'h00
);
    // Go and reserved codes are sent only when the bench asks
    task wr(input logic [7:0] a, d);
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        wr_addr_out <= a;
        wr_data_out <= d;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
        wr_data_out <= ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_addr_out <= a;
        @(posedge clk_in);
        #1 d = rd_data_in;
    endtask
endmodule // bcs_host

// File: test/test_buck_regulator_setting_regs.sv
// Bench for the converter setting bank, driven through the host model.
// Assumes a blanking count of 20 and strap defaults c5 and 10.
`timescale 1ns/1ps
module test_buck_regulator_setting_regs;
    logic clk_in = 0, rst_in = 1, write_grant_in = 0, resistor_default_select_in = 0;
    logic converter_enable_fourth_in = 0, wr_en_in, fourth_code_reserved_out;
    logic [7:0] wr_addr_in, wr_data_in, rd_addr_in, rd_data_out, v;
    logic [5:0] second_converter_voltage_code_out, third_converter_voltage_code_out;
    logic [5:0] fourth_converter_voltage_code_out;
    logic [2:0] pulse_skip_enable_out, supervision_blank_out;
    logic [7:0] rst_val [3] = '{8'h99, 8'hbd, 8'h94};
    int miscompares = 0, checks_done = 0;
    bcs_host i_host (.clk_in(clk_in), .rd_data_in(rd_data_out), .wr_en_out(wr_en_in),
        .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in), .rd_addr_out(rd_addr_in));
    bcs_setting_regs #(.BLANK_CYCLES(20), .THIRD_ALT_RESET(8'hc5), .FOURTH_ALT_RESET(8'h10))
        i_dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .wr_addr_in(wr_addr_in),
        .wr_data_in(wr_data_in), .write_grant_in(write_grant_in), .rd_addr_in(rd_addr_in),
        .resistor_default_select_in(resistor_default_select_in),
        .converter_enable_fourth_in(converter_enable_fourth_in), .rd_data_out(rd_data_out),
        .pulse_skip_enable_out(pulse_skip_enable_out),
        .second_converter_voltage_code_out(second_converter_voltage_code_out),
        .third_converter_voltage_code_out(third_converter_voltage_code_out),
        .fourth_converter_voltage_code_out(fourth_converter_voltage_code_out),
        .supervision_blank_out(supervision_blank_out),
        .fourth_code_reserved_out(fourth_code_reserved_out));
    task chk(input string n, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task rst(input logic s);
        resistor_default_select_in <= s;
        rst_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
    endtask
    initial forever #12.5 clk_in = ~clk_in;
    initial begin
        rst(1'b0);
        for (int i = 0; i < 3; i++) begin
            i_host.rd(8'h17 + 8'(i), v);
            chk("reset", v, rst_val[i]);
        end
        chk("code2", {2'h0, second_converter_voltage_code_out}, 8'h19);
        chk("code3", {2'h0, third_converter_voltage_code_out}, 8'h3d);
        chk("code4", {2'h0, fourth_converter_voltage_code_out}, 8'h14);
        chk("skip reset", {5'h00, pulse_skip_enable_out}, 8'h07);
        i_host.rd(8'h1a, v);
        chk("unmapped", v, 8'h00);
        i_host.wr(8'h18, 8'h00);
        i_host.rd(8'h18, v);
        chk("locked", v, 8'hbd);
        write_grant_in <= 1'b1;
        i_host.wr(8'h17, 8'h5f);
        i_host.rd(8'h17, v);
        chk("second", v, 8'h1f);
        chk("blank", {5'h00, supervision_blank_out}, 8'h01);
        chk("skip", {5'h00, pulse_skip_enable_out}, 8'h06);
        chk("held", {2'h0, second_converter_voltage_code_out}, 8'h19);
        i_host.wr(8'h1a, 8'h40);
        @(posedge clk_in);
        #1 chk("go", {2'h0, second_converter_voltage_code_out}, 8'h1f);
        repeat (25) @(posedge clk_in);
        #1 chk("unblank", {5'h00, supervision_blank_out}, 8'h00);
        i_host.wr(8'h19, 8'h75);
        i_host.rd(8'h19, v);
        chk("fourth", v, 8'h35);
        chk("reserved", {7'h00, fourth_code_reserved_out}, 8'h01);
        rst(1'b1);
        i_host.rd(8'h18, v);
        chk("strap3", v, 8'h85);
        i_host.rd(8'h19, v);
        chk("strap4", v, 8'h10);
        chk("strap code3", {2'h0, third_converter_voltage_code_out}, 8'h05);
        chk("strap code4", {2'h0, fourth_converter_voltage_code_out}, 8'h10);
        converter_enable_fourth_in <= 1'b1;
        i_host.wr(8'h19, 8'h94);
        #1 chk("running", {7'h00, fourth_code_reserved_out}, 8'h01);
        converter_enable_fourth_in <= 1'b0;
        i_host.rd(8'h19, v);
        chk("fourth new", v, 8'h94);
        chk("flag clear", {7'h00, fourth_code_reserved_out}, 8'h00);
        close_out;
    end
endmodule // test_buck_regulator_setting_regs
